// ==== common/dvtx_pkg.sv ====
// constants and carrier types for the pixel input capture block
// Function
// RULE_01: pixel-valid high: the captured 24-bit pixel word is what gets encoded.
// RULE_02: pixel-valid low: line sync, frame sync and aux controls get encoded.
// RULE_03: single-ended clock arrives on the positive input, negative input grounded.
// RULE_04: differential mode latches on the crossing of both clock inputs.
// RULE_05: differential clocking is only allowed with reduced-swing inputs.
// RULE_06: serial port off, width strap high: 24-bit single-edge capture.
// RULE_07: serial port off, width strap low: 12-bit dual-edge capture.
// RULE_08: serial port on: width strap becomes serial clock, selects nothing.
// RULE_09: active deskew shifts capture timing by whole fixed-size trim steps.
// RULE_10: serial port off, deskew strap high: deskew on, steps from trim select.
// RULE_11: serial port off, deskew strap low: deskew off, default trim used; the code reports the default trim but captures with NO_TRIM.
// RULE_12: serial port on: deskew from programming, strap ignored but tied.
// RULE_13: port-select high enables serial programming, low uses the straps.
// RULE_14: serial port off: clock-mode strap with reference level picks clocking; the code also needs the width strap low for differential.
// RULE_15: serial port off: edge strap high rising primary edge, low falling.
// RULE_16: 12-bit mode takes half a pixel per edge, one pixel per clock.
// RULE_17: 24-bit mode takes word, valid and syncs once, on the primary edge.
package dvtx_pkg;
  localparam int PIX_W = 24;
  localparam int HALF_W = 12;
  localparam int TRIM_W = 3;
  localparam int ADDR_W = 12;
  // register byte offsets
  localparam logic [11:0] CONFIG_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  // config and status field positions
  localparam int CFG_WIDTH24 = 0;
  localparam int CFG_DIFF = 1;
  localparam int CFG_RISING = 2;
  localparam int CFG_DESKEW = 3;
  localparam int CFG_TRIM_LO = 4;
  localparam int STS_OVERFLOW = 8;
  localparam int STS_SERIAL = 9;
  // reset and default values
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0045;
  localparam logic [2:0] DEFAULT_TRIM = 3'h4;
  localparam logic [2:0] NO_TRIM = 3'h0;
  // trim step is one system clock period
  localparam int CLK_PERIOD_PS = 4000;
  localparam int TRIM_STEP_PS = 4000;
  localparam int TRIM_STEP_CYC = (TRIM_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // one sampled set of controller inputs
  typedef struct packed {
    logic pixelValid;
    logic hsync;
    logic vsync;
    logic [2:0] auxControl;
    logic [23:0] data;
  } dvtx_pix_in_type;
  // one word handed to the encoder
  typedef struct packed {
    logic isPixel;
    logic [23:0] payload;
  } dvtx_enc_word_type;
  // effective configuration
  typedef struct packed {
    logic width24;
    logic diffClk;
    logic edgeRising;
    logic deskewOn;
    logic [2:0] trim;
  } dvtx_cfg_type;
endpackage

// ==== hw/dvtx_deskew_line.sv ====
// tapped delay line that moves data against the capture clock
`timescale 1ns/1ns
module dvtx_deskew_line #(
  parameter int WIDTH = 30,
  parameter int TAPS = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // data in and tap choice
  input wire logic [WIDTH-1:0] din,
  input wire logic [$clog2(TAPS)-1:0] tapSel,
  // delayed data
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage [TAPS];

  // tap zero is the undelayed input
  assign stage[0] = din;

  // each tap adds one trim step of delay
  for (genvar k = 1; k < TAPS; k++)
  begin : g_tap
    always_ff @(posedge clk_sys)
    begin
      if (!rst_n)
        stage[k] <= '0;
      else
        stage[k] <= stage[k-1]; // [RULE_09]
    end
  end

  // selection kept combinational so the capture edge stays aligned
  assign dout = stage[tapSel];

  property p_stepOne;
    @(posedge clk_sys) disable iff (!rst_n)
    (tapSel == 1) && $stable(tapSel) && $past(rst_n) |-> dout == $past(din);
  endproperty
  a_stepOne: assert property (p_stepOne) else $error("one trim step is not one cycle"); // [RULE_09]
endmodule

// ==== hw/dvtx_skid_buf.sv ====
// small fifo between capture and encoder
`timescale 1ns/1ns
module dvtx_skid_buf #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr;
  logic [PTR_W-1:0] rdPtr;
  logic [PTR_W:0] count;
  wire doWrite = inValid && inReady;
  wire doRead = outValid && outReady;

  // honest full and empty from the fill count
  assign inReady = (count != DEPTH[PTR_W:0]);
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];

  // storage, written only when a slot is free
  always_ff @(posedge clk_sys)
  begin
    if (doWrite)
      mem[wrPtr] <= inData;
  end

  // pointers wrap at depth
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      if (doWrite)
        wrPtr <= (wrPtr == PTR_W'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      if (doRead)
        rdPtr <= (rdPtr == PTR_W'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      count <= count + {{PTR_W{1'b0}}, doWrite} - {{PTR_W{1'b0}}, doRead};
    end
  end
endmodule

// ==== hw/dvtx_pixel_input.sv ====
// pixel bus capture, strap or programmed configuration, and apb registers
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module dvtx_pixel_input #(
  parameter int BUF_DEPTH = 2
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pixel bus from the controller, sampled clock inputs
  input wire logic pixel_clk_pos,
  input wire logic pixel_clk_neg,
  input wire logic pixel_valid,
  input wire logic hsync,
  input wire logic vsync,
  input wire logic [2:0] aux_control_in,
  input wire logic [23:0] pixelData,
  // configuration pins
  input wire logic serial_port_select,
  input wire logic bus_width_strap,
  input wire logic clock_mode_strap,
  input wire logic edge_select_strap,
  input wire logic deskew_enable_strap,
  input wire logic [2:0] trim_select,
  input wire logic lowSwingSelect,
  // serial clock handed to the serial port when it is active
  output logic serialClk,
  // words to the encoder
  output logic encValid,
  input wire logic encReady,
  output logic encIsPixel,
  output logic [23:0] encPayload,
  // room for the next capture
  output logic captureReady
);
  localparam int WORD_W = $bits(dvtx_pkg::dvtx_enc_word_type);

  logic [31:0] configReg;
  logic overflow;
  logic clkPrev;
  logic halfPending;
  logic [11:0] lowHalf;
  logic heldValid;
  logic [4:0] heldCtrl;
  logic pushValid;
  dvtx_pkg::dvtx_enc_word_type pushWord;
  dvtx_pkg::dvtx_enc_word_type bufWord;
  dvtx_pkg::dvtx_cfg_type strapCfg;
  dvtx_pkg::dvtx_cfg_type progCfg;
  dvtx_pkg::dvtx_cfg_type effCfg;
  dvtx_pkg::dvtx_pix_in_type rawIn;
  dvtx_pkg::dvtx_pix_in_type tapIn;

  // builds the encoder word for a capture
  function automatic dvtx_pkg::dvtx_enc_word_type makeWord(
    input logic valid,
    input logic [4:0] ctrl,
    input logic [23:0] pix
  );
    dvtx_pkg::dvtx_enc_word_type w;
    w.isPixel = valid;
    w.payload = valid ? pix : {19'h0, ctrl}; // [RULE_01] [RULE_02]
    return w;
  endfunction

  // strap view of the configuration
  assign strapCfg.width24 = bus_width_strap; // [RULE_06] [RULE_07]
  assign strapCfg.diffClk = clock_mode_strap && !bus_width_strap; // [RULE_14]
  assign strapCfg.edgeRising = edge_select_strap; // [RULE_15]
  assign strapCfg.deskewOn = deskew_enable_strap; // [RULE_10]
  assign strapCfg.trim = deskew_enable_strap ? trim_select : dvtx_pkg::DEFAULT_TRIM; // [RULE_10] [RULE_11]

  // programmed view; the deskew strap is not looked at here
  assign progCfg.width24 = configReg[dvtx_pkg::CFG_WIDTH24];
  assign progCfg.diffClk = configReg[dvtx_pkg::CFG_DIFF];
  assign progCfg.edgeRising = configReg[dvtx_pkg::CFG_RISING];
  assign progCfg.deskewOn = configReg[dvtx_pkg::CFG_DESKEW]; // [RULE_12]
  assign progCfg.trim = configReg[dvtx_pkg::CFG_DESKEW] ?
    configReg[dvtx_pkg::CFG_TRIM_LO +: 3] : dvtx_pkg::DEFAULT_TRIM; // [RULE_12]

  // port select picks the source; differential needs low swing either way
  wire dvtx_pkg::dvtx_cfg_type selCfg = serial_port_select ? progCfg : strapCfg; // [RULE_13]
  assign effCfg.width24 = selCfg.width24;
  assign effCfg.diffClk = selCfg.diffClk && lowSwingSelect; // [RULE_05]
  assign effCfg.edgeRising = selCfg.edgeRising;
  assign effCfg.deskewOn = selCfg.deskewOn;
  assign effCfg.trim = selCfg.trim;

  // width strap doubles as serial clock; idle high when the port is off
  assign serialClk = serial_port_select ? bus_width_strap : 1'b1; // [RULE_08]

  // clock level: crossing in differential mode, positive input alone otherwise
  wire clkLevel = effCfg.diffClk ? (pixel_clk_pos && !pixel_clk_neg) : pixel_clk_pos; // [RULE_04] [RULE_03]
  wire clkRise = clkLevel && !clkPrev;
  wire clkFall = !clkLevel && clkPrev;
  wire primaryEdge = effCfg.edgeRising ? clkRise : clkFall; // [RULE_15]
  wire secondEdge = effCfg.edgeRising ? clkFall : clkRise;

  // inputs bundled, then moved against the clock by the trim
  assign rawIn = '{pixelValid: pixel_valid, hsync: hsync, vsync: vsync,
                   auxControl: aux_control_in, data: pixelData};
  wire [2:0] tapSel = effCfg.deskewOn ? effCfg.trim : dvtx_pkg::NO_TRIM; // [RULE_09]

  dvtx_deskew_line #(
    .WIDTH($bits(dvtx_pkg::dvtx_pix_in_type)),
    .TAPS(8)
  ) u_deskew (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din(rawIn),
    .tapSel(tapSel),
    .dout(tapIn)
  );

  wire [4:0] tapCtrl = {tapIn.auxControl, tapIn.vsync, tapIn.hsync};

  // clock history for edge detection; tracks the pin in reset too, so a pin idling high gives no false edge
  always_ff @(posedge clk_sys)
  begin
    clkPrev <= clkLevel;
  end

  // first half, valid and syncs held from the primary edge in narrow mode
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      halfPending <= 1'b0;
      lowHalf <= 12'h000;
      heldValid <= 1'b0;
      heldCtrl <= 5'h00;
    end
    else if (primaryEdge && !effCfg.width24)
    begin
      halfPending <= 1'b1;
      lowHalf <= tapIn.data[11:0]; // [RULE_16]
      heldValid <= tapIn.pixelValid;
      heldCtrl <= tapCtrl;
    end
    else if (secondEdge || effCfg.width24)
      halfPending <= 1'b0;
  end

  // one word per clock period in either width
  wire wideTake = primaryEdge && effCfg.width24; // [RULE_17] [RULE_06]
  wire narrowTake = secondEdge && !effCfg.width24 && halfPending; // [RULE_07] [RULE_16]
  wire [23:0] narrowPix = {tapIn.data[11:0], lowHalf}; // [RULE_16]
  wire dvtx_pkg::dvtx_enc_word_type next_pushWord = wideTake ?
    makeWord(tapIn.pixelValid, tapCtrl, tapIn.data) : makeWord(heldValid, heldCtrl, narrowPix);

  // capture register in front of the buffer
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pushValid <= 1'b0;
      pushWord <= '0;
    end
    else
    begin
      pushValid <= wideTake || narrowTake;
      if (wideTake || narrowTake)
        pushWord <= next_pushWord;
    end
  end

  // two-entry buffer absorbs an encoder stall
  dvtx_skid_buf #(
    .WIDTH(WORD_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inValid(pushValid),
    .inReady(captureReady),
    .inData(pushWord),
    .outValid(encValid),
    .outReady(encReady),
    .outData(bufWord)
  );

  assign encIsPixel = bufWord.isPixel;
  assign encPayload = bufWord.payload;

  // apb decode; the controller cannot be stalled, so a full buffer counts as overflow
  wire apbSetup = psel && !penable;
  wire apbWrite = psel && penable && pwrite;
  wire hitConfig = (paddr == dvtx_pkg::CONFIG_OFF);
  wire hitStatus = (paddr == dvtx_pkg::STATUS_OFF);
  wire lostWord = pushValid && !captureReady;
  wire clearOverflow = apbWrite && hitStatus && pwdata[dvtx_pkg::STS_OVERFLOW];
  wire [31:0] statusWord = {22'h000000, serial_port_select, overflow, 1'b0, effCfg.trim, effCfg.deskewOn,
                            effCfg.edgeRising, effCfg.diffClk, effCfg.width24};
  assign pready = 1'b1;

  // config register and sticky overflow; a new loss wins over the clear
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      configReg <= dvtx_pkg::CONFIG_RESET;
      overflow <= 1'b0;
    end
    else
    begin
      if (apbWrite && hitConfig)
        configReg <= {25'h0000000, pwdata[6:0]};
      if (lostWord)
        overflow <= 1'b1;
      else if (clearOverflow)
        overflow <= 1'b0;
    end
  end

  // read data and error prepared in the setup cycle
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (apbSetup)
    begin
      prdata <= hitConfig ? configReg : (hitStatus ? statusWord : 32'h0000_0000);
      pslverr <= !(hitConfig || hitStatus);
    end
  end

  // checks on capture and configuration
  sequence s_wideEdge;
    primaryEdge && effCfg.width24 && $stable(effCfg);
  endsequence
  sequence s_narrowPair;
    primaryEdge && !effCfg.width24 ##[1:300] secondEdge && !effCfg.width24;
  endsequence

  property p_pixelWord;
    @(posedge clk_sys) disable iff (!rst_n)
    s_wideEdge and tapIn.pixelValid |=> pushValid && pushWord.isPixel && pushWord.payload == $past(tapIn.data);
  endproperty
  a_pixelWord: assert property (p_pixelWord) else $error("pixel word not taken"); // [RULE_01]

  property p_ctrlWord;
    @(posedge clk_sys) disable iff (!rst_n)
    s_wideEdge and !tapIn.pixelValid |=> pushValid && !pushWord.isPixel && pushWord.payload[4:0] == $past(tapCtrl);
  endproperty
  a_ctrlWord: assert property (p_ctrlWord) else $error("control word not taken"); // [RULE_02]

  property p_diffSwing;
    @(posedge clk_sys) disable iff (!rst_n)
    !lowSwingSelect |-> !effCfg.diffClk && clkLevel == pixel_clk_pos;
  endproperty
  a_diffSwing: assert property (p_diffSwing) else $error("differential clock at full swing"); // [RULE_05]

  property p_strapWidth;
    @(posedge clk_sys) disable iff (!rst_n)
    !serial_port_select |-> effCfg.width24 == bus_width_strap;
  endproperty
  a_strapWidth: assert property (p_strapWidth) else $error("width not from strap"); // [RULE_06]

  property p_serialClk;
    @(posedge clk_sys) disable iff (!rst_n)
    serial_port_select |-> serialClk == bus_width_strap && effCfg.width24 == configReg[dvtx_pkg::CFG_WIDTH24];
  endproperty
  a_serialClk: assert property (p_serialClk) else $error("width pin still steering width"); // [RULE_08]

  property p_strapTrim;
    @(posedge clk_sys) disable iff (!rst_n)
    !serial_port_select |-> tapSel == (deskew_enable_strap ? trim_select : dvtx_pkg::NO_TRIM)
      && (deskew_enable_strap || effCfg.trim == dvtx_pkg::DEFAULT_TRIM);
  endproperty
  a_strapTrim: assert property (p_strapTrim) else $error("strap deskew wrong"); // [RULE_10]

  property p_progTrim;
    @(posedge clk_sys) disable iff (!rst_n)
    serial_port_select && configReg[dvtx_pkg::CFG_DESKEW] |-> tapSel == configReg[6:4];
  endproperty
  a_progTrim: assert property (p_progTrim) else $error("programmed trim ignored"); // [RULE_12]

  property p_narrowPixel;
    @(posedge clk_sys) disable iff (!rst_n)
    s_narrowPair |=> pushValid && (pushWord.isPixel ? pushWord.payload[23:12] == $past(tapIn.data[11:0])
      : pushWord.payload[23:5] == 19'h00000);
  endproperty
  a_narrowPixel: assert property (p_narrowPixel) else $error("narrow pixel not assembled"); // [RULE_16]

  property p_onePerPeriod;
    @(posedge clk_sys) disable iff (!rst_n)
    pushValid |=> !pushValid;
  endproperty
  a_onePerPeriod: assert property (p_onePerPeriod) else $error("two captures in a row"); // [RULE_17]
endmodule

// ==== sim/dvtx_ctrl_model.sv ====
// behavioural graphics controller driving pixel clock, pixel bus and syncs
`timescale 1ns/1ns
module dvtx_ctrl_model (
  // clock and control from the bench
  input wire logic clk_sys,
  input wire logic run,
  input wire logic [2:0] mode,
  input wire dvtx_pkg::dvtx_pix_in_type word,
  // pixel bus towards the capture block
  output logic pixel_clk_pos,
  output logic pixel_clk_neg,
  output logic pixel_valid,
  output logic hsync,
  output logic vsync,
  output logic [2:0] aux_control_in,
  output logic [23:0] pixelData,
  // one pulse for each word put on the bus
  output logic taken
);
  logic [3:0] ph = 4'hB;
  logic lvl = 1'b0;
  logic busy = 1'b0;
  logic [11:0] lo;
  dvtx_pkg::dvtx_pix_in_type cur = '0;
  initial taken = 1'b0;

  // 16-cycle pixel period; the clock stands still between bursts
  always @(posedge clk_sys)
  begin
    taken <= 1'b0;
    if (ph == 4'hB && !run)
      busy <= 1'b0;
    else if (busy || run)
    begin
      busy <= 1'b1;
      ph <= ph + 4'h1;
      if (ph == 4'hB)
      begin
        cur <= word;
        taken <= 1'b1;
      end
      if (ph == 4'hF)
        lvl <= 1'b1;
      if (ph == 4'h7)
        lvl <= 1'b0;
    end
  end

  // idle at the secondary level, so a restart opens on a primary edge
  assign pixel_clk_pos = mode[2] ? lvl : !lvl;
  assign pixel_clk_neg = mode[1] ? !pixel_clk_pos : 1'b0;
  // second half rides the low lanes around the secondary edge
  assign lo = (ph >= 4'h4 && ph < 4'hC) ? cur.data[23:12] : cur.data[11:0];
  assign pixelData = mode[0] ? cur.data : {ph, ph, ph, lo}; // unused lanes carry junk
  assign pixel_valid = cur.pixelValid;
  assign hsync = cur.hsync;
  assign vsync = cur.vsync;
  assign aux_control_in = cur.auxControl;
endmodule

// ==== sim/tb.sv ====
// self-checking bench: random pixel bursts under each configuration
`timescale 1ns/1ns
module tb;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, run, taken, stall, ovf;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pixel_clk_pos, pixel_clk_neg, pixel_valid, hsync, vsync, serialClk, encValid, encReady, encIsPixel;
  logic serial_port_select, bus_width_strap, clock_mode_strap, edge_select_strap, deskew_enable_strap;
  logic lowSwingSelect, captureReady;
  logic [2:0] aux_control_in, trim_select, mode;
  logic [23:0] pixelData, encPayload;
  dvtx_pkg::dvtx_pix_in_type word;
  logic [24:0] expq [$];
  int err_count, compares, ntaken;
  // per case: cfg[13:6] lowswing[5] deskew[4] edge[3] clkmode[2] width[1] serial[0]
  logic [13:0] cases [7] = '{14'h000A, 14'h0010, 14'h002C, 14'h001C, 14'h0AE1, 14'h0491, 14'h0026};

  dvtx_pixel_input dvtx_pixel_input_i (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pixel_clk_pos, .pixel_clk_neg, .pixel_valid, .hsync, .vsync, .aux_control_in,
    .pixelData, .serial_port_select, .bus_width_strap, .clock_mode_strap, .edge_select_strap,
    .deskew_enable_strap, .trim_select, .lowSwingSelect, .serialClk, .encValid, .encReady, .encIsPixel,
    .encPayload, .captureReady);
  dvtx_ctrl_model dvtx_ctrl_model_i (.clk_sys, .run, .mode, .word, .pixel_clk_pos, .pixel_clk_neg,
    .pixel_valid, .hsync, .vsync, .aux_control_in, .pixelData, .taken);

  // 250 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // watchdog: whole run needs under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    test_done;
  end

  // encoder word expected for one presented set of inputs
  function automatic logic [24:0] enc(dvtx_pkg::dvtx_pix_in_type w);
    return w.pixelValid ? {1'b1, w.data} : {1'b0, 19'h0, w.auxControl, w.vsync, w.hsync};
  endfunction

  // effective configuration as the status register should show it
  function automatic logic [31:0] exp_sts(logic [13:0] c, logic [2:0] t);
    logic w, d, r, k;
    logic [2:0] tr;
    logic [7:0] g;
    g = c[13:6];
    if (c[0])
    begin
      {w, d, r, k} = {g[0], g[1] & c[5], g[2], g[3]};
      tr = g[3] ? g[6:4] : dvtx_pkg::DEFAULT_TRIM;
    end
    else
    begin
      {w, d, r, k} = {c[1], c[2] & !c[1] & c[5], c[3], c[4]};
      tr = c[4] ? t : dvtx_pkg::DEFAULT_TRIM;
    end
    return {22'h0, c[0], 2'b00, tr, k, r, d, w};
  endfunction

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic test_done;
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      err_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reset_dut;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask

  // n words from the controller, then wait for the encoder side to drain
  task automatic burst(input int n);
    int k;
    ntaken = 0;
    k = 0;
    run <= 1'b1;
    while (ntaken < n && k < 500)
    begin
      @(posedge clk_sys);
      k++;
    end
    run <= 1'b0;
    chk("words sent", 32'(n), 32'(ntaken));
    k = 0;
    while (expq.size() != 0 && k < 300)
    begin
      @(posedge clk_sys);
      k++;
    end
    chk("words left", 32'h0, 32'(expq.size()));
  endtask

  // scoreboard, random stall and serial clock pin activity
  always @(posedge clk_sys)
  begin
    if (taken && !ovf)
      expq.push_back(enc(word));
    if (taken)
    begin
      ntaken++;
      word <= 30'($urandom);
      if (serial_port_select)
        bus_width_strap <= 1'($urandom);
    end
    if (encValid === 1'b1 && encReady === 1'b1 && !ovf)
    begin
      if (expq.size() == 0)
        chk("extra word", 32'h0, 32'h1);
      else
        chk("word", {7'h0, expq.pop_front()}, {7'h0, encIsPixel, encPayload});
    end
    chk("serialClk", {31'h0, serial_port_select ? bus_width_strap : 1'b1}, {31'h0, serialClk});
    encReady <= !stall && $urandom_range(3) != 0;
  end

  initial
  begin
    logic [31:0] r, ex;
    logic e;
    logic [13:0] c;
    logic [2:0] t;
    void'($urandom(32'hECE5));
    {psel, penable, pwrite, paddr, pwdata, run, stall, ovf, encReady} = '0;
    {serial_port_select, bus_width_strap, clock_mode_strap, edge_select_strap} = 4'h4;
    {deskew_enable_strap, trim_select, lowSwingSelect} = '0;
    mode = 3'h5;
    word = '0;
    {rst_n, err_count, compares, ntaken} = '0;
    reset_dut;
    // register reset value, writable bits and an unmapped place
    apb(1'b0, dvtx_pkg::CONFIG_OFF, 32'h0, r, e);
    chk("config reset", dvtx_pkg::CONFIG_RESET, r);
    apb(1'b1, dvtx_pkg::CONFIG_OFF, 32'hFFFFFFFF, r, e);
    apb(1'b0, dvtx_pkg::CONFIG_OFF, 32'h0, r, e);
    chk("config bits", 32'h0000007F, r);
    apb(1'b1, 12'h008, 32'hFFFFFFFF, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    apb(1'b0, 12'h008, 32'h0, r, e);
    chk("unmapped data", 32'h0, r);
    // each configuration: strap or programmed, then a random burst
    for (int i = 0; i < 7; i++)
    begin
      c = cases[i];
      t = 3'($urandom_range(2));
      ex = exp_sts(c, t);
      {deskew_enable_strap, edge_select_strap, clock_mode_strap, bus_width_strap} <= c[4:1];
      {serial_port_select, lowSwingSelect, trim_select, mode} <= {c[0], c[5], t, ex[2:0]};
      reset_dut;
      if (c[0])
        apb(1'b1, dvtx_pkg::CONFIG_OFF, {24'h0, c[13:6]}, r, e);
      burst(5);
      apb(1'b0, dvtx_pkg::STATUS_OFF, 32'h0, r, e);
      chk("status", ex, r);
      chk("status err", 32'h0, {31'h0, e});
    end
    // encoder stalled: buffer fills, words are lost and flagged
    stall <= 1'b1;
    ovf <= 1'b1;
    burst(6);
    chk("capture full", 32'h0, {31'h0, captureReady});
    apb(1'b0, dvtx_pkg::STATUS_OFF, 32'h0, r, e);
    chk("overflow set", 32'h1, {31'h0, r[8]});
    stall <= 1'b0;
    repeat (40) @(posedge clk_sys);
    apb(1'b1, dvtx_pkg::STATUS_OFF, 32'h100, r, e);
    apb(1'b0, dvtx_pkg::STATUS_OFF, 32'h0, r, e);
    chk("overflow clear", 32'h0, {31'h0, r[8]});
    test_done;
  end
endmodule
